/* design/mip_pkg.sv */
// constants and types for the mic input path control registers
package mip_pkg;
    // -----------------------------------------------------------------
    // control port
    // -----------------------------------------------------------------
    localparam logic [6:0] DEV_ADDR = 7'h1a;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam int SYNC_STAGES = 3;
    localparam int PIN_COUNT = 4;

    // -----------------------------------------------------------------
    // register offsets (register address in the control word)
    // -----------------------------------------------------------------
    localparam logic [6:0] OFF_PWR_ONE = 7'h01;
    localparam logic [6:0] OFF_PWR_TWO = 7'h02;
    localparam logic [6:0] OFF_LEVEL_ONE = 7'h20;
    localparam logic [6:0] OFF_ROUTING = 7'h2c;
    localparam logic [6:0] OFF_GAIN = 7'h2d;

    // -----------------------------------------------------------------
    // field positions
    // -----------------------------------------------------------------
    localparam int BIT_SEC_BUF_EN = 6;
    localparam int BIT_GAIN_AMP_EN = 2;
    localparam int BIT_AUTO_LEVEL = 8;
    localparam int BIT_POS_PIN = 0;
    localparam int BIT_NEG_PIN = 1;
    localparam int BIT_SEC_INPUT = 2;
    localparam int BIT_MIXER = 3;
    localparam int GAIN_MSB = 5;
    localparam int BIT_MUTE = 6;
    localparam int BIT_ZERO_CROSS = 7;

    // -----------------------------------------------------------------
    // reset values
    // -----------------------------------------------------------------
    localparam logic [8:0] RST_PWR_ONE = 9'h000;
    localparam logic [8:0] RST_PWR_TWO = 9'h000;
    localparam logic [8:0] RST_LEVEL_ONE = 9'h000;
    localparam logic [8:0] RST_ROUTING = 9'h003;
    localparam logic [8:0] RST_GAIN = 9'h010;

    // -----------------------------------------------------------------
    // two-wire receiver states
    // -----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SHIFT = 4'b0010,
        ST_ACK = 4'b0100,
        ST_IGNORE = 4'b1000
    } mip_ser_state_t;
endpackage

/* design/mip_wr_if.sv */
// register write carrier between control port and register bank
`timescale 1ns/1ps
interface mip_wr_if;
    logic wr_stb;
    logic [6:0] wr_addr;
    logic [8:0] wr_data;
    logic three_wire;

    modport port (output wr_stb, output wr_addr, output wr_data,
                  output three_wire);
    modport regs (input wr_stb, input wr_addr, input wr_data,
                  input three_wire);
endinterface

/* design/mip_ser_port.sv */
// serial control port: three-wire shifter and two-wire slave receiver
`timescale 1ns/1ps
module mip_ser_port (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // control pins
    input wire logic sclk,
    input wire logic sdin,
    input wire logic csb,
    input wire logic mode,
    output logic sdin_oe,
    // write carrier
    mip_wr_if.port wr
);
    // -----------------------------------------------------------------
    // pin synchronisers and glitch filter
    // -----------------------------------------------------------------
    logic [mip_pkg::SYNC_STAGES-1:0] sync_ff [mip_pkg::PIN_COUNT];
    logic [mip_pkg::SYNC_STAGES-1:0] nxt_sync [mip_pkg::PIN_COUNT];
    logic [3:0] filt_ff, nxt_filt, pins;

    assign pins = {mode, csb, sdin, sclk};

    // a change counts only once second and third stage agree
    always_comb begin
        for (int i = 0; i < mip_pkg::PIN_COUNT; i++) begin
            nxt_sync[i] = {sync_ff[i][1:0], pins[i]};
            nxt_filt[i] = (sync_ff[i][1] == sync_ff[i][2]) ?
                          sync_ff[i][2] : filt_ff[i];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            // data and select start at their idle high level, so the
            // edge detectors see no false edge once reset lets go
            sync_ff[0] <= 3'h0;
            sync_ff[1] <= 3'h7;
            sync_ff[2] <= 3'h7;
            sync_ff[3] <= 3'h0;
            filt_ff <= 4'h6;
        end else begin
            sync_ff <= nxt_sync;
            filt_ff <= nxt_filt;
        end
    end

    logic scl_rise, scl_fall, sda_rise, sda_fall, cs_rise, three_w;
    assign scl_rise = !filt_ff[0] && nxt_filt[0];
    assign scl_fall = filt_ff[0] && !nxt_filt[0];
    assign sda_rise = !filt_ff[1] && nxt_filt[1];
    assign sda_fall = filt_ff[1] && !nxt_filt[1];
    assign cs_rise = !filt_ff[2] && nxt_filt[2];
    assign three_w = filt_ff[3];

    // -----------------------------------------------------------------
    // receiver state
    // -----------------------------------------------------------------
    mip_pkg::mip_ser_state_t st_ff, nxt_st;
    logic [15:0] sh_ff, nxt_sh;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [1:0] byte_ff, nxt_byte;
    logic [6:0] reg_addr_ff, nxt_reg_addr;
    logic d8_ff, nxt_d8, oe_ff, nxt_oe, stb_ff, nxt_stb;
    logic [15:0] word_ff, nxt_word;

    // one frame of 7 address and 9 data bits in both protocols
    always_comb begin
        nxt_st = st_ff;
        nxt_sh = sh_ff;
        nxt_cnt = cnt_ff;
        nxt_byte = byte_ff;
        nxt_reg_addr = reg_addr_ff;
        nxt_d8 = d8_ff;
        nxt_oe = oe_ff;
        nxt_stb = 1'b0;
        nxt_word = word_ff;
        if (three_w) begin
            nxt_st = mip_pkg::ST_IDLE;
            nxt_oe = 1'b0;
            if (scl_rise && !filt_ff[2]) begin
                nxt_sh = {sh_ff[14:0], filt_ff[1]};
            end
            if (cs_rise) begin
                nxt_stb = 1'b1;
                nxt_word = sh_ff;
            end
        end else begin
            unique case (st_ff)
                mip_pkg::ST_IDLE, mip_pkg::ST_IGNORE: begin
                end
                mip_pkg::ST_SHIFT: begin
                    if (scl_rise) begin
                        nxt_sh = {sh_ff[14:0], filt_ff[1]};
                        nxt_cnt = cnt_ff + 4'h1;
                    end
                    if (scl_fall && cnt_ff == mip_pkg::BYTE_BITS) begin
                        nxt_cnt = 4'h0;
                        nxt_oe = 1'b1;
                        nxt_st = mip_pkg::ST_ACK;
                        if (byte_ff == 2'h0) begin
                            // answer only our own address, writes only
                            if (sh_ff[7:1] != mip_pkg::DEV_ADDR
                                || sh_ff[0]) begin
                                nxt_oe = 1'b0;
                                nxt_st = mip_pkg::ST_IGNORE;
                            end
                        end else if (byte_ff == 2'h1) begin
                            nxt_reg_addr = sh_ff[7:1];
                            nxt_d8 = sh_ff[0];
                        end else begin
                            nxt_stb = 1'b1;
                            nxt_word = {reg_addr_ff, d8_ff, sh_ff[7:0]};
                        end
                    end
                end
                mip_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        nxt_oe = 1'b0;
                        nxt_byte = byte_ff + 2'h1;
                        nxt_st = (byte_ff == 2'h2) ? mip_pkg::ST_IGNORE :
                                 mip_pkg::ST_SHIFT;
                    end
                end
            endcase
            // start and stop win over any byte in progress
            if (filt_ff[0] && sda_fall) begin
                nxt_st = mip_pkg::ST_SHIFT;
                nxt_cnt = 4'h0;
                nxt_byte = 2'h0;
                nxt_oe = 1'b0;
            end else if (filt_ff[0] && sda_rise) begin
                nxt_st = mip_pkg::ST_IDLE;
                nxt_oe = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_ff <= mip_pkg::ST_IDLE;
            sh_ff <= 16'h0000;
            cnt_ff <= 4'h0;
            byte_ff <= 2'h0;
            reg_addr_ff <= 7'h00;
            d8_ff <= 1'b0;
            oe_ff <= 1'b0;
            stb_ff <= 1'b0;
            word_ff <= 16'h0000;
        end else begin
            st_ff <= nxt_st;
            sh_ff <= nxt_sh;
            cnt_ff <= nxt_cnt;
            byte_ff <= nxt_byte;
            reg_addr_ff <= nxt_reg_addr;
            d8_ff <= nxt_d8;
            oe_ff <= nxt_oe;
            stb_ff <= nxt_stb;
            word_ff <= nxt_word;
        end
    end

    assign sdin_oe = oe_ff;
    assign wr.wr_stb = stb_ff;
    assign wr.wr_addr = word_ff[15:9];
    assign wr.wr_data = word_ff[8:0];
    assign wr.three_wire = three_w;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_mode_quiet: assert property (
        three_w |=> !sdin_oe
    ) else $error("two-wire acknowledge driven in three-wire mode");
    a_addr_match: assert property (
        st_ff == mip_pkg::ST_ACK && byte_ff == 2'h0 |->
            sh_ff[7:1] == mip_pkg::DEV_ADDR && sdin_oe
    ) else $error("acknowledged a foreign bus address");
    c_two_wire_write: cover property (
        !three_w && stb_ff
    );
    c_three_wire_write: cover property (
        three_w && stb_ff
    );
endmodule

/* design/mip_regs.sv */
// mic input path control register bank with deferred gain update
//
// Contract
// - mode pin high three-wire, low two-wire
// - two-wire slave answers only address 0011010
// - routing bit0 picks positive pin or reference
// - routing bit1 connects negative pin, resets one
// - routing bit2 connects secondary input, resets zero
// - power two bit2 enables gain amplifier
// - six-bit gain code, reset code 010000
// - one gain code serves every amplifier path
// - gain bit6 mutes and isolates the amplifier
// - gain bit7 defers update to zero crossing
// - level bit8 hands gain to level loop
// - power one bit6 enables secondary buffer
// - routing bit3 picks inverting buffer or mixer
`timescale 1ns/1ps
module mip_regs (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // serial control pins
    input wire logic sclk,
    input wire logic sdin,
    input wire logic csb,
    input wire logic mode,
    output logic sdin_out,
    output logic sdin_oe,
    // analogue side inputs
    input wire logic sig_sign,
    input wire logic [5:0] alc_gain,
    // amplifier and switch controls
    output logic pos_pin_to_gain_amp,
    output logic neg_pin_to_gain_amp,
    output logic second_input_to_gain_amp,
    output logic gain_amp_enable,
    output logic [5:0] gain_amp_volume,
    output logic gain_amp_mute,
    output logic second_input_buffer_enable,
    output logic second_input_mixer_select,
    // status
    output logic three_wire_mode,
    output logic gain_update_pending
);
    // -----------------------------------------------------------------
    // control port
    // -----------------------------------------------------------------
    mip_wr_if wr ();

    mip_ser_port u_port (
        .clk(clk),
        .rstn(rstn),
        .sclk(sclk),
        .sdin(sdin),
        .csb(csb),
        .mode(mode),
        .sdin_oe(sdin_oe),
        .wr(wr.port)
    );

    // open-drain acknowledge only ever pulls low
    assign sdin_out = 1'b0;
    assign three_wire_mode = wr.three_wire;

    function automatic logic hit(input logic [6:0] off);
        return wr.wr_stb && wr.wr_addr == off;
    endfunction

    // -----------------------------------------------------------------
    // register storage
    // -----------------------------------------------------------------
    logic [8:0] pwr_one_ff, nxt_pwr_one;
    logic [8:0] pwr_two_ff, nxt_pwr_two;
    logic [8:0] level_one_ff, nxt_level_one;
    logic [8:0] routing_ff, nxt_routing;
    logic [8:0] gain_ff, nxt_gain;

    // unmapped addresses are dropped silently; the port has no readback
    always_comb begin
        nxt_pwr_one = pwr_one_ff;
        nxt_pwr_two = pwr_two_ff;
        nxt_level_one = level_one_ff;
        nxt_routing = routing_ff;
        nxt_gain = gain_ff;
        if (hit(mip_pkg::OFF_PWR_ONE)) nxt_pwr_one = wr.wr_data;
        if (hit(mip_pkg::OFF_PWR_TWO)) nxt_pwr_two = wr.wr_data;
        if (hit(mip_pkg::OFF_LEVEL_ONE)) nxt_level_one = wr.wr_data;
        if (hit(mip_pkg::OFF_ROUTING)) nxt_routing = wr.wr_data;
        if (hit(mip_pkg::OFF_GAIN)) nxt_gain = wr.wr_data;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pwr_one_ff <= mip_pkg::RST_PWR_ONE;
            pwr_two_ff <= mip_pkg::RST_PWR_TWO;
            level_one_ff <= mip_pkg::RST_LEVEL_ONE;
            routing_ff <= mip_pkg::RST_ROUTING;
            gain_ff <= mip_pkg::RST_GAIN;
        end else begin
            pwr_one_ff <= nxt_pwr_one;
            pwr_two_ff <= nxt_pwr_two;
            level_one_ff <= nxt_level_one;
            routing_ff <= nxt_routing;
            gain_ff <= nxt_gain;
        end
    end

    // -----------------------------------------------------------------
    // switch and enable outputs
    // -----------------------------------------------------------------
    assign pos_pin_to_gain_amp = routing_ff[mip_pkg::BIT_POS_PIN];
    assign neg_pin_to_gain_amp = routing_ff[mip_pkg::BIT_NEG_PIN];
    assign second_input_to_gain_amp =
        routing_ff[mip_pkg::BIT_SEC_INPUT];
    assign second_input_mixer_select = routing_ff[mip_pkg::BIT_MIXER];
    assign gain_amp_enable = pwr_two_ff[mip_pkg::BIT_GAIN_AMP_EN];
    assign second_input_buffer_enable =
        pwr_one_ff[mip_pkg::BIT_SEC_BUF_EN];
    assign gain_amp_mute = gain_ff[mip_pkg::BIT_MUTE];

    // -----------------------------------------------------------------
    // zero-crossing gain update
    // -----------------------------------------------------------------
    logic [2:0] sgn_ff, nxt_sgn;
    logic sgn_f_ff, nxt_sgn_f, crossing, gain_wr, defer;
    logic [5:0] active_ff, nxt_active, amp_ff, nxt_amp;
    logic pend_ff, nxt_pend;

    // sign comes from an analogue comparator, so it is synchronised
    always_comb begin
        nxt_sgn = {sgn_ff[1:0], sig_sign};
        nxt_sgn_f = (sgn_ff[1] == sgn_ff[2]) ? sgn_ff[2] : sgn_f_ff;
        crossing = (sgn_ff[1] == sgn_ff[2]) && (sgn_ff[2] != sgn_f_ff);
    end

    assign gain_wr = hit(mip_pkg::OFF_GAIN);
    assign defer = gain_ff[mip_pkg::BIT_ZERO_CROSS];

    // a write arriving with a crossing keeps its pending flag
    always_comb begin
        nxt_active = active_ff;
        nxt_pend = pend_ff;
        if (!defer) begin
            nxt_active = gain_ff[mip_pkg::GAIN_MSB:0];
            nxt_pend = 1'b0;
        end else if (crossing && pend_ff) begin
            nxt_active = gain_ff[mip_pkg::GAIN_MSB:0];
            nxt_pend = 1'b0;
        end
        if (gain_wr && wr.wr_data[mip_pkg::BIT_ZERO_CROSS]) begin
            nxt_pend = 1'b1;
        end
        // loop owns the amplifier while it is selected
        nxt_amp = level_one_ff[mip_pkg::BIT_AUTO_LEVEL] ? alc_gain :
                  active_ff;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            sgn_ff <= 3'h0;
            sgn_f_ff <= 1'b0;
            active_ff <= mip_pkg::RST_GAIN[5:0];
            amp_ff <= mip_pkg::RST_GAIN[5:0];
            pend_ff <= 1'b0;
        end else begin
            sgn_ff <= nxt_sgn;
            sgn_f_ff <= nxt_sgn_f;
            active_ff <= nxt_active;
            amp_ff <= nxt_amp;
            pend_ff <= nxt_pend;
        end
    end

    // one code drives every input path of the amplifier
    assign gain_amp_volume = amp_ff;
    assign gain_update_pending = pend_ff;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_pos_route: assert property (
        wr.wr_stb && wr.wr_addr == mip_pkg::OFF_ROUTING |=>
            pos_pin_to_gain_amp == $past(wr.wr_data[0])
    ) else $error("positive pin switch did not follow write");
    a_neg_route: assert property (
        wr.wr_stb && wr.wr_addr == mip_pkg::OFF_ROUTING |=>
            neg_pin_to_gain_amp == $past(wr.wr_data[1])
    ) else $error("negative pin switch did not follow write");
    a_route_reset: assert property (
        !$past(rstn) |-> pos_pin_to_gain_amp && neg_pin_to_gain_amp
            && !second_input_to_gain_amp && !second_input_mixer_select
    ) else $error("routing switches wrong after reset");
    a_amp_enable: assert property (
        wr.wr_stb && wr.wr_addr == mip_pkg::OFF_PWR_TWO |=>
            gain_amp_enable == $past(wr.wr_data[2])
    ) else $error("amplifier enable did not follow write");
    a_gain_reset: assert property (
        !$past(rstn) |-> gain_amp_volume == 6'h10 && !gain_amp_mute
    ) else $error("gain code wrong after reset");
    a_mute_bit: assert property (
        wr.wr_stb && wr.wr_addr == mip_pkg::OFF_GAIN |=>
            gain_amp_mute == $past(wr.wr_data[6])
    ) else $error("mute did not follow write");
    a_gain_direct: assert property (
        gain_wr && !wr.wr_data[7] && !level_one_ff[8]
            ##1 !wr.wr_stb ##1 !wr.wr_stb |=>
            gain_amp_volume == $past(wr.wr_data[5:0], 3)
    ) else $error("direct gain update not applied in three cycles");
    a_alc_follow: assert property (
        level_one_ff[8] |=> gain_amp_volume == $past(alc_gain)
    ) else $error("level loop gain not passed to amplifier");
    a_sec_buffer: assert property (
        wr.wr_stb && wr.wr_addr == mip_pkg::OFF_PWR_ONE |=>
            second_input_buffer_enable == $past(wr.wr_data[6])
    ) else $error("secondary buffer enable did not follow write");
    a_zc_hold: assert property (
        defer && !crossing && !gain_wr && pend_ff |=>
            $stable(active_ff) && pend_ff
    ) else $error("deferred gain applied without a crossing");
    c_deferred_load: cover property (
        pend_ff && crossing ##1 !pend_ff
    );
    c_alc_on: cover property (
        level_one_ff[8] && !defer
    );
endmodule

/* tb/mip_host.sv */
// host processor model driving the serial control port pins
`timescale 1ns/1ps
module mip_host (
    // clock
    input wire logic clk,
    // control pins toward the device
    output logic sclk,
    output logic sdin_h,
    output logic csb,
    output logic mode,
    // resolved data line
    input wire logic sdin_line
);
    // idle: three-wire, clock parked low, select high
    initial begin
        sclk = 1'b0;
        sdin_h = 1'b1;
        csb = 1'b1;
        mode = 1'b1;
    end

    // -----------------------------------------------------------------
    // pin phases
    // -----------------------------------------------------------------
    // six clocks a phase keeps every level past the pin filter
    task automatic drive(input logic c, input logic d, input logic s);
        @(posedge clk);
        sclk <= c;
        sdin_h <= d;
        csb <= s;
        repeat (5) @(posedge clk);
    endtask

    task automatic set_mode(input logic m);
        @(posedge clk);
        mode <= m;
        repeat (7) @(posedge clk);
    endtask

    // -----------------------------------------------------------------
    // frames
    // -----------------------------------------------------------------
    // address then data, msb first; data line inverted once released
    task automatic write3(input logic [6:0] a, input logic [8:0] d);
        logic [15:0] w;
        w = {a, d};
        for (int i = 15; i >= 0; i--) begin
            drive(1'b0, w[i], 1'b0);
            drive(1'b1, w[i], 1'b0);
        end
        drive(1'b0, ~w[0], 1'b1);
    endtask

    // data moves only while the clock is low, never with its edge,
    // or the device would see a start or stop in mid-byte
    task automatic bit2(input logic b);
        drive(1'b0, sdin_h, 1'b1);
        drive(1'b0, b, 1'b1);
        drive(1'b1, b, 1'b1);
    endtask

    // start, three bytes each followed by an ack slot, stop
    task automatic write2(input logic [7:0] dev, input logic [6:0] a,
                          input logic [8:0] d, output int acks);
        logic [23:0] w;
        w = {dev, a, d};
        acks = 0;
        drive(1'b1, 1'b1, 1'b1);
        drive(1'b1, 1'b0, 1'b1);
        for (int i = 23; i >= 0; i--) begin
            bit2(w[i]);
            if (i % 8 == 0) begin
                bit2(1'b1);
                if (sdin_line === 1'b0) acks++;
            end
        end
        bit2(1'b0);
        drive(1'b1, 1'b1, 1'b1);
    endtask
endmodule

/* tb/test_mip_input_path_control_regs.sv */
// self-checking bench for the mic input path control registers
`timescale 1ns/1ps
module test_mip_input_path_control_regs;
    logic clk = 1'b0;
    logic rstn, sig_sign, sclk, sdin_h, csb, mode, sdin_line;
    logic sdin_out, sdin_oe, pos, neg, sec, mix, amp_en, mute;
    logic buf_en, tw_mode, pending;
    logic [5:0] alc_gain, vol;
    logic [8:0] pwr1, pwr2, lvl, rout, gain;
    logic [5:0] act;
    logic [6:0] a;
    logic [8:0] d;
    logic [6:0] addrs [6] = '{7'h01, 7'h02, 7'h20, 7'h2c, 7'h2d, 7'h7f};
    int fails = 0;
    int checks = 0;
    int acks;
    integer seed = 32'h941e;

    always #12.5 clk = ~clk;

    // open-drain data line: device only ever pulls low
    assign sdin_line = sdin_oe ? sdin_out : sdin_h;

    mip_host host (.clk(clk), .sclk(sclk), .sdin_h(sdin_h), .csb(csb),
        .mode(mode), .sdin_line(sdin_line));

    mip_regs uut (.clk(clk), .rstn(rstn), .sclk(sclk), .sdin(sdin_line),
        .csb(csb), .mode(mode), .sdin_out(sdin_out), .sdin_oe(sdin_oe),
        .sig_sign(sig_sign), .alc_gain(alc_gain),
        .pos_pin_to_gain_amp(pos), .neg_pin_to_gain_amp(neg),
        .second_input_to_gain_amp(sec), .gain_amp_enable(amp_en),
        .gain_amp_volume(vol), .gain_amp_mute(mute),
        .second_input_buffer_enable(buf_en),
        .second_input_mixer_select(mix), .three_wire_mode(tw_mode),
        .gain_update_pending(pending));

    // -----------------------------------------------------------------
    // checking
    // -----------------------------------------------------------------
    task automatic summarize();
        if (fails == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(string n, logic [8:0] seen, logic [8:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // the level loop overrides the programmed code
    function automatic logic [5:0] exp_vol();
        return lvl[8] ? alc_gain : act;
    endfunction

    task automatic check_all(input logic pend);
        check("pos_pin", 9'(pos), 9'(rout[0]));
        check("neg_pin", 9'(neg), 9'(rout[1]));
        check("second_in", 9'(sec), 9'(rout[2]));
        check("mixer", 9'(mix), 9'(rout[3]));
        check("amp_en", 9'(amp_en), 9'(pwr2[2]));
        check("buf_en", 9'(buf_en), 9'(pwr1[6]));
        check("mute", 9'(mute), 9'(gain[6]));
        check("volume", 9'(vol), 9'(exp_vol()));
        check("pending", 9'(pending), 9'(pend));
        check("three_wire", 9'(tw_mode), 9'(mode));
    endtask

    // one register write, shadow update, then a full output compare
    task automatic wr(input logic [6:0] ad, input logic [8:0] dd,
                      input logic two);
        int n;
        if (two) begin
            host.write2(8'h34, ad, dd, n);
            check("ack_count", 9'(n), 9'h003);
        end else host.write3(ad, dd);
        repeat (12) @(posedge clk);
        case (ad)
            7'h01: pwr1 = dd;
            7'h02: pwr2 = dd;
            7'h20: lvl = dd;
            7'h2c: rout = dd;
            7'h2d: begin
                gain = dd;
                if (!dd[7]) act = dd[5:0];
            end
            default: ;
        endcase
        // deferred code holds until the input changes sign
        if (ad == 7'h2d && dd[7]) begin
            check_all(1'b1);
            @(posedge clk) sig_sign <= ~sig_sign;
            repeat (10) @(posedge clk);
            act = dd[5:0];
        end
        check_all(1'b0);
    endtask

    // -----------------------------------------------------------------
    // watchdog
    // -----------------------------------------------------------------
    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        summarize();
    end

    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        sig_sign = 1'b0;
        alc_gain = 6'h00;
        pwr1 = 9'h000;
        pwr2 = 9'h000;
        lvl = 9'h000;
        rout = 9'h003;
        gain = 9'h010;
        act = 6'h10;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
        check_all(1'b0);
        // gain code end points, mute, deferred update
        wr(7'h2d, 9'h000, 1'b0);
        wr(7'h2d, 9'h07f, 1'b0);
        wr(7'h2d, 9'h0a5, 1'b0);
        wr(7'h7f, 9'h1ff, 1'b0);
        // level loop owns the gain
        alc_gain <= 6'h2a;
        wr(7'h20, 9'h100, 1'b0);
        wr(7'h20, 9'h000, 1'b0);
        for (int i = 0; i < 14; i++) begin
            a = addrs[$unsigned($random(seed)) % 6];
            d = 9'($random(seed));
            // host leaves the manual code alone under the loop
            if (lvl[8] && a == 7'h2d) a = 7'h2c;
            alc_gain <= 6'($random(seed));
            wr(a, d, 1'b0);
        end
        // two-wire port: single-ended then positive pin plus secondary input setup
        host.set_mode(1'b0);
        host.drive(1'b1, 1'b1, 1'b1);
        wr(7'h2c, 9'h002, 1'b1);
        wr(7'h2c, 9'h005, 1'b1);
        // wrong address and read request draw no ack, no write
        host.write2(8'h36, 7'h2c, 9'h00e, acks);
        check("ack_none", 9'(acks), 9'h000);
        host.write2(8'h35, 7'h2c, 9'h00e, acks);
        check("ack_read", 9'(acks), 9'h000);
        check_all(1'b0);
        summarize();
    end
endmodule
